// ### logic/cdcreq_pkg.sv
package cdcreq_pkg;

   // ==========================================================
   // Request and notification codes
   localparam logic [7:0]  CR_TYPE_OUT     = 8'h21;
   localparam logic [7:0]  CR_TYPE_IN      = 8'hA1;
   localparam logic [7:0]  CR_REQ_SET_LC   = 8'h20;
   localparam logic [7:0]  CR_REQ_GET_LC   = 8'h21;
   localparam logic [7:0]  CR_REQ_SET_CTL  = 8'h22;
   localparam logic [7:0]  CR_REQ_BREAK    = 8'h23;
   localparam logic [7:0]  CR_NTF_NETWORK  = 8'h00;
   localparam logic [7:0]  CR_NTF_RESP     = 8'h01;
   localparam logic [7:0]  CR_NTF_SERIAL   = 8'h20;
   localparam logic [15:0] CR_ZERO16       = 16'h0000;
   localparam logic [15:0] CR_LC_LEN       = 16'h0007;
   localparam logic [15:0] CR_SSTATE_MASK  = 16'h007F;

   // ==========================================================
   // Line coding limits
   localparam logic [7:0]  CR_STOP_MAX     = 8'h02;
   localparam logic [7:0]  CR_PARITY_MAX   = 8'h04;
   localparam logic [7:0]  CR_BITS_MIN     = 8'h05;
   localparam logic [7:0]  CR_BITS_MAX     = 8'h08;

   // ==========================================================
   // Byte counts
   localparam logic [3:0]  CR_SETUP_BYTES  = 4'h8;
   localparam logic [3:0]  CR_LC_BYTES     = 4'h7;
   localparam logic [3:0]  CR_NTF_HDR_LAST = 4'h7;
   localparam logic [3:0]  CR_NTF_PAY_LO   = 4'h8;
   localparam logic [3:0]  CR_NTF_PAY_HI   = 4'h9;

   // ==========================================================
   // Register offsets
   localparam logic [11:0] CR_OFS_CMD      = 12'h000;
   localparam logic [11:0] CR_OFS_STATUS   = 12'h004;
   localparam logic [11:0] CR_OFS_LC_RATE  = 12'h008;
   localparam logic [11:0] CR_OFS_LC_FMT   = 12'h00C;
   localparam logic [11:0] CR_OFS_CTL_MAP  = 12'h010;
   localparam logic [11:0] CR_OFS_BRK_MS   = 12'h014;
   localparam logic [11:0] CR_OFS_SSTATE   = 12'h018;
   localparam logic [11:0] CR_OFS_IRQ_STAT = 12'h01C;
   localparam logic [11:0] CR_OFS_IRQ_MASK = 12'h020;
   localparam logic [11:0] CR_OFS_TXDATA   = 12'h024;
   localparam logic [11:0] CR_OFS_RXDATA   = 12'h028;

   // ==========================================================
   // Interrupt and control bit positions, reset values
   localparam int          CR_IRQ_W        = 5;
   localparam int          CR_IRQ_DONE     = 0;
   localparam int          CR_IRQ_SERIAL   = 1;
   localparam int          CR_IRQ_RESP     = 2;
   localparam int          CR_IRQ_BAD      = 3;
   localparam int          CR_IRQ_RXDATA   = 4;
   localparam int          CR_CTL_DTR_BIT  = 0;
   localparam int          CR_CTL_RTS_BIT  = 1;
   localparam logic [31:0] CR_RATE_RESET   = 32'h0001_C200;

   // ==========================================================
   // Types
   typedef enum logic [2:0] {
      CR_OP_NONE    = 3'b000,
      CR_OP_SET_LC  = 3'b001,
      CR_OP_GET_LC  = 3'b010,
      CR_OP_SET_CTL = 3'b011,
      CR_OP_BREAK   = 3'b100
   } cr_op_t;

   typedef enum logic [1:0] {
      CR_IDLE = 2'b00,
      CR_SEND = 2'b01,
      CR_WAIT = 2'b10
   } cr_state_t;

   typedef struct packed {
      logic [15:0] w_length;
      logic [15:0] w_index;
      logic [15:0] w_value;
      logic [7:0]  b_request;
      logic [7:0]  bm_type;
   } cr_setup_t;

   typedef struct packed {
      logic [7:0]  data_bits;
      logic [7:0]  parity;
      logic [7:0]  stop_bits;
      logic [31:0] rate;
   } cr_coding_t;

   localparam cr_coding_t CR_LC_RESET = '{data_bits: 8'h08, parity: 8'h00, stop_bits: 8'h00,
                                          rate: CR_RATE_RESET};

   // ==========================================================
   // Helpers
   function automatic logic cr_lc_valid(cr_coding_t lc);
      return (lc.stop_bits <= CR_STOP_MAX) && (lc.parity <= CR_PARITY_MAX) &&
             (lc.data_bits >= CR_BITS_MIN) && (lc.data_bits <= CR_BITS_MAX);
   endfunction : cr_lc_valid

   function automatic cr_setup_t cr_mk_setup(logic [7:0] t, logic [7:0] r, logic [15:0] v, logic [15:0] l);
      return '{w_length: l, w_index: CR_ZERO16, w_value: v, b_request: r, bm_type: t};
   endfunction : cr_mk_setup

endpackage : cdcreq_pkg

// ### logic/cdcreq_setup_tx.sv
`timescale 1ns/10ps
module cdcreq_setup_tx import cdcreq_pkg::*; (
   input  wire logic       clk_sys_i,
   input  wire logic       rst_n,
   input  wire logic       start_i,
   input  wire cr_setup_t  setup_i,
   input  wire cr_coding_t coding_i,
   input  wire logic [3:0] dlen_i,
   output logic            valid_o,
   output logic [7:0]      data_o,
   output logic            stage_setup_o,
   output logic            last_o,
   input  wire logic       ready_i,
   output logic            done_o
);

   // ==========================================================
   // Byte serialiser, setup stage then optional data stage
   logic [119:0] sh_q;
   logic [3:0]   sent_q;
   logic [3:0]   total_q;
   logic         valid_q;
   logic         stg_q;
   logic         last_q;

   wire       xfer   = valid_q & ready_i;
   wire [3:0] sent_d = sent_q + 4'h1;

   always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         sh_q    <= '0;
         sent_q  <= '0;
         total_q <= '0;
         valid_q <= 1'b0;
         stg_q   <= 1'b0;
         last_q  <= 1'b0;
      end else if (start_i && !valid_q) begin
         sh_q    <= {coding_i, setup_i};
         sent_q  <= '0;
         total_q <= CR_SETUP_BYTES + dlen_i;
         valid_q <= 1'b1;
         stg_q   <= 1'b1;
         last_q  <= 1'b0;
      end else if (xfer) begin
         sh_q    <= {8'h00, sh_q[119:8]};
         sent_q  <= sent_d;
         valid_q <= ~last_q;
         stg_q   <= sent_d < CR_SETUP_BYTES;
         last_q  <= sent_d == (total_q - 4'h1);
      end
   end

   assign valid_o       = valid_q;
   assign data_o        = sh_q[7:0];
   assign stage_setup_o = stg_q;
   assign last_o        = last_q;
   assign done_o        = xfer & last_q;

endmodule : cdcreq_setup_tx

// ### logic/cdcreq_notif_rx.sv
`timescale 1ns/10ps
module cdcreq_notif_rx import cdcreq_pkg::*; (
   input  wire logic       clk_sys_i,
   input  wire logic       rst_n,
   input  wire logic       valid_i,
   input  wire logic [7:0] data_i,
   input  wire logic       last_i,
   output logic            resp_o,
   output logic            serial_o,
   output logic [15:0]     map_o
);

   // ==========================================================
   // Notification parser
   logic [3:0]  cnt_q;
   logic [7:0]  type_q;
   logic [7:0]  req_q;
   logic [7:0]  lo_q;
   logic        resp_q;
   logic        ser_q;
   logic [15:0] map_q;

   wire is_in  = type_q == CR_TYPE_IN;
   wire hdr_end = valid_i & (cnt_q == CR_NTF_HDR_LAST);
   wire pay_end = valid_i & (cnt_q == CR_NTF_PAY_HI);

   always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q  <= '0;
         type_q <= '0;
         req_q  <= '0;
         lo_q   <= '0;
         resp_q <= 1'b0;
         ser_q  <= 1'b0;
         map_q  <= '0;
      end else begin
         resp_q <= hdr_end & is_in & (req_q == CR_NTF_RESP);
         ser_q  <= pay_end & is_in & (req_q == CR_NTF_SERIAL);
         if (pay_end && is_in && req_q == CR_NTF_SERIAL) begin
            map_q <= {data_i, lo_q} & CR_SSTATE_MASK;
         end
         if (valid_i) begin
            cnt_q <= last_i ? 4'h0 : (cnt_q == 4'hF ? cnt_q : cnt_q + 4'h1);
            if (cnt_q == 4'h0) begin
               type_q <= data_i;
            end
            if (cnt_q == 4'h1) begin
               req_q <= data_i;
            end
            if (cnt_q == CR_NTF_PAY_LO) begin
               lo_q <= data_i;
            end
         end
      end
   end

   assign resp_o   = resp_q;
   assign serial_o = ser_q;
   assign map_o    = map_q;

endmodule : cdcreq_notif_rx

// ### logic/cdcreq_host.sv
// The register addresses and the APB interface to the registers were left to the implementer.
`timescale 1ns/10ps
// Function
// - Rate: four bytes little-endian at offset zero
// - Offset four: stop bits 0,1,2
// - Offset six: data bits five to eight
// - Bitmap bit one drives RTS
// - Bitmap bit zero drives DTR
// - Peripheral sends serial state as A1
// - State bits six..four: overrun, parity, framing
// - State bit three ring, two break
// - State bit one DSR, zero DCD
// - Response available carries no payload
module cdcreq_host import cdcreq_pkg::*; (
   input  wire logic        clk_sys_i,
   input  wire logic        rstn_i,
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [11:0] paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic [31:0]      prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   output logic             ctl_tx_valid_o,
   output logic [7:0]       ctl_tx_data_o,
   output logic             ctl_tx_setup_o,
   output logic             ctl_tx_last_o,
   input  wire logic        ctl_tx_ready_i,
   input  wire logic        ctl_rx_valid_i,
   input  wire logic [7:0]  ctl_rx_data_i,
   input  wire logic        ctl_done_i,
   input  wire logic        ntf_valid_i,
   input  wire logic [7:0]  ntf_data_i,
   input  wire logic        ntf_last_i,
   output logic             blk_tx_valid_o,
   output logic [7:0]       blk_tx_data_o,
   input  wire logic        blk_tx_ready_i,
   input  wire logic        blk_rx_valid_i,
   input  wire logic [7:0]  blk_rx_data_i,
   output logic             blk_rx_ready_o,
   output logic             irq_o
);

   // ==========================================================
   // Reset release
   logic rst_m_q;
   logic rst_n;

   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rst_m_q <= 1'b0;
         rst_n   <= 1'b0;
      end else begin
         rst_m_q <= 1'b1;
         rst_n   <= rst_m_q;
      end
   end

   // ==========================================================
   // State
   cr_state_t            st_q;
   cr_op_t               op_q;
   cr_setup_t            setup_q;
   logic [3:0]           dlen_q;
   logic                 go_q;
   cr_coding_t           lc_q;
   cr_coding_t           lc_rx_q;
   logic [3:0]           rxcnt_q;
   logic [1:0]           ctl_map_q;
   logic [15:0]          brk_ms_q;
   logic [15:0]          sstate_q;
   logic [CR_IRQ_W-1:0]  ist_q;
   logic [CR_IRQ_W-1:0]  imsk_q;
   logic                 irq_q;
   logic [31:0]          prdata_q;
   logic                 pready_q;
   logic                 pslverr_q;
   logic                 btx_v_q;
   logic [7:0]           btx_d_q;
   logic                 brx_full_q;
   logic [7:0]           brx_d_q;
   logic                 brx_rdy_q;
   logic                 tx_done;
   logic                 ntf_resp;
   logic                 ntf_ser;
   logic [15:0]          ntf_map;

   // ==========================================================
   // APB decode
   wire setup_ph = psel_i & ~penable_i;
   wire acc_done = psel_i & penable_i & pready_q;
   wire wr       = acc_done & pwrite_i;
   wire rd       = acc_done & ~pwrite_i;

   wire hit_cmd  = paddr_i == CR_OFS_CMD;
   wire hit_sts  = paddr_i == CR_OFS_STATUS;
   wire hit_rate = paddr_i == CR_OFS_LC_RATE;
   wire hit_fmt  = paddr_i == CR_OFS_LC_FMT;
   wire hit_ctl  = paddr_i == CR_OFS_CTL_MAP;
   wire hit_brk  = paddr_i == CR_OFS_BRK_MS;
   wire hit_ss   = paddr_i == CR_OFS_SSTATE;
   wire hit_ist  = paddr_i == CR_OFS_IRQ_STAT;
   wire hit_imk  = paddr_i == CR_OFS_IRQ_MASK;
   wire hit_tx   = paddr_i == CR_OFS_TXDATA;
   wire hit_rx   = paddr_i == CR_OFS_RXDATA;
   wire mapped   = hit_cmd | hit_sts | hit_rate | hit_fmt | hit_ctl | hit_brk | hit_ss |
                   hit_ist | hit_imk | hit_tx | hit_rx;
   wire busy     = st_q != CR_IDLE;

   wire [31:0] rd_mux =
      hit_cmd  ? {29'h0, op_q} :
      hit_sts  ? {27'h0, btx_v_q, brx_full_q, st_q, busy} :
      hit_rate ? lc_q.rate :
      hit_fmt  ? {8'h00, lc_q.data_bits, lc_q.parity, lc_q.stop_bits} :
      hit_ctl  ? {30'h0, ctl_map_q} :
      hit_brk  ? {16'h0000, brk_ms_q} :
      hit_ss   ? {16'h0000, sstate_q} :
      hit_ist  ? {27'h0, ist_q} :
      hit_imk  ? {27'h0, imsk_q} :
      hit_rx   ? {brx_full_q, 23'h0, brx_d_q} : 32'h0000_0000;

   always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= '0;
      end else begin
         pready_q  <= setup_ph;
         pslverr_q <= setup_ph & ~mapped;
         prdata_q  <= setup_ph ? rd_mux : prdata_q;
      end
   end

   // ==========================================================
   // Command decode
   wire    cmd_wr = wr & hit_cmd & ~busy;
   cr_op_t op_w;
   assign  op_w = cr_op_t'(pwdata_i[2:0]);
   wire    op_ok  = (op_w == CR_OP_SET_LC) | (op_w == CR_OP_GET_LC) | (op_w == CR_OP_SET_CTL) |
                    (op_w == CR_OP_BREAK);
   wire    lc_ok  = cr_lc_valid(lc_q);
   wire    go     = cmd_wr & op_ok & ((op_w != CR_OP_SET_LC) | lc_ok);
   wire    bad    = cmd_wr & ~go;

   wire [15:0] ctl_val = {14'h0000, ctl_map_q};
   wire cr_setup_t setup_w =
      (op_w == CR_OP_SET_LC)  ? cr_mk_setup(CR_TYPE_OUT, CR_REQ_SET_LC, CR_ZERO16, CR_LC_LEN) :
      (op_w == CR_OP_GET_LC)  ? cr_mk_setup(CR_TYPE_IN, CR_REQ_GET_LC, CR_ZERO16, CR_LC_LEN) :
      (op_w == CR_OP_SET_CTL) ? cr_mk_setup(CR_TYPE_OUT, CR_REQ_SET_CTL, ctl_val, CR_ZERO16) :
                                cr_mk_setup(CR_TYPE_OUT, CR_REQ_BREAK, brk_ms_q, CR_ZERO16);

   // ==========================================================
   // Request sequencer
   wire rx_take = (st_q == CR_WAIT) & (op_q == CR_OP_GET_LC) & ctl_rx_valid_i & (rxcnt_q < CR_LC_BYTES);
   wire fin     = (st_q == CR_WAIT) & ctl_done_i;
   wire get_ok  = fin & (op_q == CR_OP_GET_LC) & (rxcnt_q == CR_LC_BYTES);
   wire get_bad = fin & (op_q == CR_OP_GET_LC) & ((rxcnt_q != CR_LC_BYTES) | ~cr_lc_valid(lc_rx_q));

   always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         st_q    <= CR_IDLE;
         op_q    <= CR_OP_NONE;
         setup_q <= '0;
         dlen_q  <= '0;
         go_q    <= 1'b0;
         rxcnt_q <= '0;
         lc_rx_q <= '0;
      end else begin
         go_q <= go;
         unique case (st_q)
            CR_IDLE: begin
               if (go) begin
                  st_q    <= CR_SEND;
                  op_q    <= op_w;
                  setup_q <= setup_w;
                  dlen_q  <= (op_w == CR_OP_SET_LC) ? CR_LC_BYTES : 4'h0;
                  rxcnt_q <= '0;
               end
            end
            CR_SEND: begin
               if (tx_done) begin
                  st_q <= CR_WAIT;
               end
            end
            CR_WAIT: begin
               if (rx_take) begin
                  lc_rx_q <= {ctl_rx_data_i, lc_rx_q[55:8]};
                  rxcnt_q <= rxcnt_q + 4'h1;
               end
               if (fin) begin
                  st_q <= CR_IDLE;
               end
            end
            default: st_q <= CR_IDLE;
         endcase
      end
   end

   cdcreq_setup_tx u_tx (
      .clk_sys_i     (clk_sys_i),
      .rst_n         (rst_n),
      .start_i       (go_q),
      .setup_i       (setup_q),
      .coding_i      (lc_q),
      .dlen_i        (dlen_q),
      .valid_o       (ctl_tx_valid_o),
      .data_o        (ctl_tx_data_o),
      .stage_setup_o (ctl_tx_setup_o),
      .last_o        (ctl_tx_last_o),
      .ready_i       (ctl_tx_ready_i),
      .done_o        (tx_done)
   );

   cdcreq_notif_rx u_ntf (
      .clk_sys_i (clk_sys_i),
      .rst_n     (rst_n),
      .valid_i   (ntf_valid_i),
      .data_i    (ntf_data_i),
      .last_i    (ntf_last_i),
      .resp_o    (ntf_resp),
      .serial_o  (ntf_ser),
      .map_o     (ntf_map)
   );

   // ==========================================================
   // Configuration registers
   always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         lc_q      <= CR_LC_RESET;
         ctl_map_q <= '0;
         brk_ms_q  <= '0;
         sstate_q  <= '0;
         imsk_q    <= '0;
      end else begin
         if (get_ok && cr_lc_valid(lc_rx_q)) begin
            lc_q <= lc_rx_q;
         end else if (wr && hit_rate) begin
            lc_q.rate <= pwdata_i;
         end else if (wr && hit_fmt) begin
            lc_q.stop_bits <= pwdata_i[7:0];
            lc_q.parity    <= pwdata_i[15:8];
            lc_q.data_bits <= pwdata_i[23:16];
         end
         if (wr && hit_ctl) begin
            ctl_map_q[CR_CTL_RTS_BIT] <= pwdata_i[CR_CTL_RTS_BIT];
            ctl_map_q[CR_CTL_DTR_BIT] <= pwdata_i[CR_CTL_DTR_BIT];
         end
         if (wr && hit_brk) begin
            brk_ms_q <= pwdata_i[15:0];
         end
         if (ntf_ser) begin
            sstate_q <= ntf_map;
         end
         if (wr && hit_imk) begin
            imsk_q <= pwdata_i[CR_IRQ_W-1:0];
         end
      end
   end

   // ==========================================================
   // Serial data both ways
   wire brx_take = blk_rx_valid_i & brx_rdy_q;
   wire brx_pop  = rd & hit_rx & brx_full_q;
   wire brx_full_d = brx_take | (brx_full_q & ~brx_pop);

   always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         btx_v_q    <= 1'b0;
         btx_d_q    <= '0;
         brx_full_q <= 1'b0;
         brx_d_q    <= '0;
         brx_rdy_q  <= 1'b0;
      end else begin
         if (wr && hit_tx && !btx_v_q) begin
            btx_v_q <= 1'b1;
            btx_d_q <= pwdata_i[7:0];
         end else if (btx_v_q && blk_tx_ready_i) begin
            btx_v_q <= 1'b0;
         end
         if (brx_take) begin
            brx_d_q <= blk_rx_data_i;
         end
         brx_full_q <= brx_full_d;
         brx_rdy_q  <= ~brx_full_d;
      end
   end

   // ==========================================================
   // Interrupts
   logic [CR_IRQ_W-1:0] ev;
   always_comb begin
      ev                = '0;
      ev[CR_IRQ_DONE]   = fin;
      ev[CR_IRQ_SERIAL] = ntf_ser;
      ev[CR_IRQ_RESP]   = ntf_resp;
      ev[CR_IRQ_BAD]    = bad | get_bad;
      ev[CR_IRQ_RXDATA] = brx_take;
   end
   wire [CR_IRQ_W-1:0] w1c   = (wr & hit_ist) ? pwdata_i[CR_IRQ_W-1:0] : '0;
   wire [CR_IRQ_W-1:0] ist_d = (ist_q & ~w1c) | ev;

   always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         ist_q <= '0;
         irq_q <= 1'b0;
      end else begin
         ist_q <= ist_d;
         irq_q <= |(ist_d & imsk_q);
      end
   end

   assign prdata_o       = prdata_q;
   assign pready_o       = pready_q;
   assign pslverr_o      = pslverr_q;
   assign blk_tx_valid_o = btx_v_q;
   assign blk_tx_data_o  = btx_d_q;
   assign blk_rx_ready_o = brx_rdy_q;
   assign irq_o          = irq_q;

   // ==========================================================
   // Assertions
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n);

   sequence s_go(cr_op_t o);
      go && op_w == o;
   endsequence

   a_get_setup: assert property (s_go(CR_OP_GET_LC) |=> setup_q == 64'h0007_0000_0000_21A1)
      else $error("get coding setup wrong");
   a_set_lc_len: assert property (s_go(CR_OP_SET_LC) |=> dlen_q == 4'h7 && setup_q.b_request == 8'h20)
      else $error("set coding request wrong");
   a_ctl_bitmap: assert property (s_go(CR_OP_SET_CTL) |=> setup_q.w_value == {14'h0, $past(ctl_map_q)}
      && setup_q.w_length == 16'h0 && setup_q.b_request == 8'h22)
      else $error("control line request wrong");
   a_break_value: assert property (s_go(CR_OP_BREAK) |=> setup_q.w_value == $past(brk_ms_q)
      && setup_q.b_request == 8'h23)
      else $error("break request wrong");
   a_bad_refused: assert property (cmd_wr && op_w == CR_OP_SET_LC && !lc_ok |=> st_q == CR_IDLE
      && ist_q[CR_IRQ_BAD])
      else $error("invalid coding not refused");
   a_sstate_rsvd: assert property (ntf_ser |=> sstate_q[15:7] == 9'h000)
      else $error("reserved state bits kept");
   a_tx_first: assert property (go |=> ##1 ctl_tx_valid_o && ctl_tx_setup_o
      && ctl_tx_data_o == setup_q.bm_type)
      else $error("setup stage did not start");
   a_rx_backpr: assert property (brx_take |=> !blk_rx_ready_o && brx_full_q)
      else $error("rx byte not held");
   a_apb_answer: assert property (setup_ph |=> pready_o ##1 !pready_o || setup_ph)
      else $error("apb answer timing");

endmodule : cdcreq_host

// ### test/cdcreq_periph_model.sv
`timescale 1ns/10ps
module cdcreq_periph_model import cdcreq_pkg::*; (
   input  wire logic       clk_sys_i,
   input  wire logic       slow_i,
   input  wire logic       tv_i,
   input  wire logic [7:0] td_i,
   input  wire logic       tl_i,
   output logic            tr_o,
   output logic            xv_o,
   output logic [7:0]      xd_o,
   output logic            dn_o,
   output logic            nv_o,
   output logic [7:0]      nd_o,
   output logic            nl_o,
   input  wire logic       bv_i,
   input  wire logic [7:0] bd_i,
   output logic            yv_o,
   output logic [7:0]      yd_o,
   input  wire logic       yr_i
);
   // ======
   // Peripheral side of control, notify and bulk pipes
   logic [7:0] got[$];
   logic [7:0] bgot[$];
   logic [7:0] xq = 8'h00, nq = 8'h00, yq = 8'h00;
   logic       tick = 1'b0;
   cr_coding_t ans = CR_LC_RESET;
   initial {tr_o, xv_o, dn_o, nv_o, nl_o, yv_o} = '0;
   // Released lines show the inverse of the last byte
   assign xd_o = xv_o ? xq : ~xq;
   assign nd_o = nv_o ? nq : ~nq;
   assign yd_o = yv_o ? yq : ~yq;
   always @(posedge clk_sys_i) begin
      tick <= ~tick;
      tr_o <= !slow_i || tick;
      if (bv_i && tr_o) bgot.push_back(bd_i);
      if (tv_i && tr_o) got.push_back(td_i);
      if (tv_i && tr_o && tl_i) fork reply(); join_none
   end
   task automatic reply();
      logic [55:0] b;
      b = ans;
      repeat (2) @(posedge clk_sys_i);
      if (got[1] == CR_REQ_GET_LC) begin
         for (int i = 0; i < 7; i++) begin
            xv_o <= 1'b1;
            xq <= b[8*i +: 8];
            @(posedge clk_sys_i);
         end
      end
      xv_o <= 1'b0;
      dn_o <= 1'b1;
      @(posedge clk_sys_i);
      dn_o <= 1'b0;
   endtask : reply
   task automatic send_ntf(input logic [79:0] pk, input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge clk_sys_i);
         nv_o <= 1'b1;
         nq <= pk[8*i +: 8];
         nl_o <= (i == n - 1);
      end
      @(posedge clk_sys_i);
      {nv_o, nl_o} <= 2'b00;
   endtask : send_ntf
   task automatic send_bulk(input logic [7:0] b);
      @(posedge clk_sys_i);
      yv_o <= 1'b1;
      yq <= b;
      do @(posedge clk_sys_i); while (!yr_i);
      yv_o <= 1'b0;
   endtask : send_bulk
endmodule : cdcreq_periph_model

// ### test/cdc_acm_host_request_codec_bench.sv
`timescale 1ns/10ps
module cdc_acm_host_request_codec_bench import cdcreq_pkg::*; ();
   // ======
   // Wiring
   logic        clk_sys_i = 1'b0, rstn_i = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, slow = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rv;
   logic        pready, pslverr, irq, tv, tl, tr, xv, dn, nv, nl, bv, yv, yr, ts, se;
   logic [7:0]  td, xd, nd, bd, yd;
   int          err_count = 0, checks_done = 0, nset = 0;
   always #2.5 clk_sys_i = ~clk_sys_i;
   cdcreq_host uut (.clk_sys_i, .rstn_i, .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
      .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .ctl_tx_valid_o(tv),
      .ctl_tx_data_o(td), .ctl_tx_setup_o(ts), .ctl_tx_last_o(tl), .ctl_tx_ready_i(tr), .ctl_rx_valid_i(xv),
      .ctl_rx_data_i(xd), .ctl_done_i(dn), .ntf_valid_i(nv), .ntf_data_i(nd), .ntf_last_i(nl), .blk_tx_valid_o(bv),
      .blk_tx_data_o(bd), .blk_tx_ready_i(tr), .blk_rx_valid_i(yv), .blk_rx_data_i(yd), .blk_rx_ready_o(yr),
      .irq_o(irq));
   cdcreq_periph_model periph (.clk_sys_i, .slow_i(slow), .tv_i(tv), .td_i(td), .tl_i(tl), .tr_o(tr), .xv_o(xv),
      .xd_o(xd), .dn_o(dn), .nv_o(nv), .nd_o(nd), .nl_o(nl), .bv_i(bv), .bd_i(bd), .yv_o(yv), .yd_o(yd), .yr_i(yr));
   // Counts bytes accepted while flagged as setup stage
   always @(posedge clk_sys_i) if (tv && tr && ts) nset++;
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks_done++;
      if (g !== e) begin
         err_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk_sys_i);
      {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
      @(posedge clk_sys_i);
      penable <= 1'b1;
      do @(posedge clk_sys_i); while (pready !== 1'b1);
      rv = prdata;
      se = pslverr;
      {psel, penable} <= 2'b00;
   endtask : apb
   task automatic run(input logic [2:0] op, input logic [119:0] e, input int n, input logic [31:0] st);
      periph.got.delete();
      nset = 0;
      apb(1'b1, CR_OFS_CMD, {29'h0, op});
      for (int k = 0; k < 300 && irq !== 1'b1; k++) @(posedge clk_sys_i);
      repeat (2) @(posedge clk_sys_i);
      for (int i = 0; i < n; i++) chk({24'h0, periph.got[i]}, {24'h0, e[8*i +: 8]});
      chk(periph.got.size(), n);
      chk(nset, (n > 0) ? 8 : 0);
      apb(1'b0, CR_OFS_IRQ_STAT, 32'h0);
      chk(rv, st);
      apb(1'b1, CR_OFS_IRQ_STAT, 32'h1F);
   endtask : run
   task automatic ntf(input logic [79:0] pk, input int n, input logic [31:0] st, input logic iq);
      periph.send_ntf(pk, n);
      repeat (4) @(posedge clk_sys_i);
      apb(1'b0, CR_OFS_IRQ_STAT, 32'h0);
      chk(rv, st);
      chk({31'h0, irq}, {31'h0, iq});
      apb(1'b1, CR_OFS_IRQ_STAT, 32'h1F);
   endtask : ntf
   task automatic t_lc();
      apb(1'b1, CR_OFS_IRQ_MASK, 32'h1F);
      slow <= 1'b1;
      apb(1'b1, CR_OFS_LC_RATE, 32'h0000_2580);
      apb(1'b1, CR_OFS_LC_FMT, 32'h0007_0202);
      run(3'h1, {56'h07_0202_0000_2580, 16'h0007, 32'h0, 8'h20, 8'h21}, 15, 32'h1);
      apb(1'b1, CR_OFS_LC_FMT, 32'h0008_0500);
      run(3'h1, 120'h0, 0, 32'h8);
      slow <= 1'b0;
      periph.ans = {8'h06, 8'h04, 8'h01, 32'h0001_2C00};
      run(3'h2, {56'h0, 16'h0007, 32'h0, 8'h21, 8'hA1}, 8, 32'h1);
      apb(1'b0, CR_OFS_LC_RATE, 32'h0);
      chk(rv, 32'h0001_2C00);
      periph.ans = {8'h08, 8'h05, 8'h00, 32'h0};
      run(3'h2, {56'h0, 16'h0007, 32'h0, 8'h21, 8'hA1}, 8, 32'h9);
      apb(1'b0, CR_OFS_LC_FMT, 32'h0);
      chk(rv, 32'h0006_0401);
      $display("line coding test done");
   endtask : t_lc
   task automatic t_ctl();
      apb(1'b1, CR_OFS_CTL_MAP, 32'hFFFF_FFFF);
      run(3'h3, {88'h0, 16'h0003, 8'h22, 8'h21}, 8, 32'h1);
      apb(1'b1, CR_OFS_CTL_MAP, 32'h0000_0002);
      run(3'h3, {88'h0, 16'h0002, 8'h22, 8'h21}, 8, 32'h1);
      apb(1'b1, CR_OFS_BRK_MS, 32'h1234_ABCD);
      run(3'h4, {88'h0, 16'hABCD, 8'h23, 8'h21}, 8, 32'h1);
      run(3'h5, 120'h0, 0, 32'h8);
      apb(1'b0, CR_OFS_STATUS, 32'h0);
      chk(rv, 32'h0);
      apb(1'b0, 12'h02C, 32'h0);
      chk({rv[31:1], se}, 32'h1);
      $display("control test done");
   endtask : t_ctl
   task automatic t_ntf();
      ntf({16'hFFD5, 16'h0002, 32'h0, 8'h20, 8'hA1}, 10, 32'h2, 1'b1);
      apb(1'b0, CR_OFS_SSTATE, 32'h0);
      chk(rv, 32'h0000_0055);
      apb(1'b1, CR_OFS_IRQ_MASK, 32'h0);
      ntf({16'h0, 48'h0, 8'h01, 8'hA1}, 8, 32'h4, 1'b0);
      ntf({16'h0, 48'h0, 8'h00, 8'hA1}, 8, 32'h0, 1'b0);
      apb(1'b1, CR_OFS_TXDATA, 32'h0000_005A);
      repeat (8) @(posedge clk_sys_i);
      chk({24'h0, periph.bgot[0]}, 32'h5A);
      periph.send_bulk(8'hC3);
      apb(1'b0, CR_OFS_RXDATA, 32'h0);
      chk(rv, 32'h8000_00C3);
      $display("notify and bulk test done");
   endtask : t_ntf
   task automatic summarize();
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : summarize
   initial begin
      repeat (4) @(posedge clk_sys_i);
      rstn_i <= 1'b1;
      repeat (3) @(posedge clk_sys_i);
      t_lc();
      t_ctl();
      t_ntf();
      summarize();
   end
   initial begin
      #100000;
      err_count++;
      summarize();
   end
endmodule : cdc_acm_host_request_codec_bench
